// [core/ivp_vector_priority.sv]
`timescale 1ns/1ps
`default_nettype none

module ivp_vector_priority
(
    input wire logic sys_clk_i,                    // 25 MHz system clock
    input wire logic reset_i,                      // synchronous, active high
    input wire ivp_pkg::ivp_req_type req_i,        // source flags
    input wire logic global_int_enable_i,          // gie from cpu status
    input wire logic serial_a_spi_mode_i,          // 1 = spi, 0 = uart
    input wire logic serial_b_i2c_mode_i,          // 1 = i2c, 0 = spi
    input wire logic [15:0] vector_word_i [ivp_pkg::SRC_COUNT], // table contents
    output logic vector_valid_o,                   // a vector is pending
    output ivp_pkg::ivp_class_type vector_class_o, // reset, nmi, maskable
    output logic [15:0] vector_addr_o,             // word address of slot
    output logic [5:0] vector_priority_o,          // priority of slot
    output logic [15:0] handler_ptr_o,             // pc load value
    output ivp_pkg::ivp_index_type index_o         // shared vector indexes
);

    // lowest set bit gives 2*(n+1), zero when idle
    function automatic logic [7:0] first_index(input logic [15:0] flags);
        logic [7:0] res;
        res = 8'h00;
        for (int i = 15; i >= 0; i--)
        begin
            if (flags[i])
            begin
                res = 8'((i + 1) * 2);
            end
        end
        return res;
    endfunction : first_index

    logic [3:0] sa_eff;
    logic [13:0] sb_eff;
    logic [ivp_pkg::SRC_COUNT-1:0] raw_req;
    logic [ivp_pkg::SRC_COUNT-1:0] gated_req;
    logic [3:0] win_nxt;
    logic vector_valid_r;
    ivp_pkg::ivp_class_type vector_class_r;
    logic [15:0] vector_addr_r;
    logic [5:0] vector_priority_r;
    logic [15:0] handler_ptr_r;
    logic [15:0] ptr_sel;
    ivp_pkg::ivp_index_type index_r;
    ivp_pkg::ivp_index_type index_nxt;
    ivp_pkg::ivp_class_type class_nxt;

    // mode masks drop flags the current mode never raises
    assign sa_eff = serial_a_spi_mode_i ? (req_i.serial_a & ivp_pkg::SA_SPI_MASK)
                                        : req_i.serial_a;
    assign sb_eff = serial_b_i2c_mode_i ? req_i.serial_b
                                        : (req_i.serial_b & ivp_pkg::SB_SPI_MASK);

    // one request line per slot
    always_comb
    begin
        raw_req = '0;
        raw_req[ivp_pkg::SLOT_RESET] = |req_i.reset_src;
        raw_req[ivp_pkg::SLOT_SYS_NMI] = |req_i.sys_nmi_src;
        raw_req[ivp_pkg::SLOT_USR_NMI] = |req_i.usr_nmi_src;
        raw_req[ivp_pkg::SLOT_T0_CH0] = req_i.compare_channel0_flag;
        raw_req[ivp_pkg::SLOT_T0_GRP] = |req_i.timer0_grp;
        raw_req[ivp_pkg::SLOT_WDOG] = req_i.watchdog_flag;
        raw_req[ivp_pkg::SLOT_SER_A] = |sa_eff;
        raw_req[ivp_pkg::SLOT_SER_B] = |sb_eff;
        raw_req[ivp_pkg::SLOT_CONV] = |req_i.converter;
        raw_req[ivp_pkg::SLOT_PORT1] = |req_i.port1;
        raw_req[ivp_pkg::SLOT_PORT2] = |req_i.port2;
    end

    // gie masks only the maskable slots below the nmi slots
    always_comb
    begin
        gated_req = raw_req;
        for (int s = 0; s < int'(ivp_pkg::SLOT_USR_NMI); s++)
        begin
            gated_req[s] = raw_req[s] & global_int_enable_i;
        end
    end

    // upward scan so the highest pending slot is the last to win
    always_comb
    begin
        win_nxt = 4'(ivp_pkg::SLOT_NONE);
        for (int s = 0; s < int'(ivp_pkg::SLOT_NONE); s++)
        begin
            if (gated_req[s])
            begin
                win_nxt = 4'(s);
            end
        end
    end

    // class follows the winning slot
    always_comb
    begin
        case (win_nxt)
            4'(ivp_pkg::SLOT_RESET): class_nxt = ivp_pkg::CLASS_RESET;
            4'(ivp_pkg::SLOT_SYS_NMI): class_nxt = ivp_pkg::CLASS_NMI;
            4'(ivp_pkg::SLOT_USR_NMI): class_nxt = ivp_pkg::CLASS_NMI;
            4'(ivp_pkg::SLOT_NONE): class_nxt = ivp_pkg::CLASS_NONE;
            default: class_nxt = ivp_pkg::CLASS_MASKABLE;
        endcase
    end

    // index values; shared groups report their lowest pending flag
    always_comb
    begin
        index_nxt.timer0_vector_index = first_index({13'h0000, req_i.timer0_grp});
        index_nxt.serial_a_vector_index = first_index({12'h000, sa_eff});
        index_nxt.serial_b_vector_index = first_index({2'h0, sb_eff});
        index_nxt.converter_vector_index = first_index({10'h000, req_i.converter});
        index_nxt.port1_vector_index = first_index({8'h00, req_i.port1});
        index_nxt.port2_vector_index = first_index({8'h00, req_i.port2});
    end

    // selected vector; table lookup keeps the slot address inside the window
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            vector_valid_r <= 1'b0;
            vector_class_r <= ivp_pkg::CLASS_NONE;
            vector_addr_r <= 16'h0000;
            vector_priority_r <= 6'h00;
        end
        else
        begin
            vector_valid_r <= (win_nxt != 4'(ivp_pkg::SLOT_NONE));
            vector_class_r <= class_nxt;
            vector_addr_r <= ivp_pkg::VEC_ADDR[win_nxt];
            vector_priority_r <= ivp_pkg::VEC_PRIO[win_nxt];
        end
    end

    // table word of the winning slot, one net so the load check sees the same value
    assign ptr_sel = vector_word_i[win_nxt];

    // pointer the cpu loads into its program counter
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            handler_ptr_r <= 16'h0000;
        end
        else if (win_nxt != 4'(ivp_pkg::SLOT_NONE))
        begin
            handler_ptr_r <= ptr_sel;
        end
        else
        begin
            handler_ptr_r <= 16'h0000;
        end
    end

    // index registers, read by the handler to pick the cause
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            index_r <= '0;
        end
        else
        begin
            index_r <= index_nxt;
        end
    end

    assign vector_valid_o = vector_valid_r;
    assign vector_class_o = vector_class_r;
    assign vector_addr_o = vector_addr_r;
    assign vector_priority_o = vector_priority_r;
    assign handler_ptr_o = handler_ptr_r;
    assign index_o = index_r;

    // checks
    chk_addr_window: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        vector_valid_o |-> (vector_addr_o >= ivp_pkg::TABLE_BOTTOM && !vector_addr_o[0]))
        else $error("vector address outside table");

    chk_ptr_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (win_nxt != 4'(ivp_pkg::SLOT_NONE)) |=> handler_ptr_o == $past(ptr_sel))
        else $error("handler pointer not loaded");

    chk_reset_top: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (|req_i.reset_src) |=> (vector_addr_o == 16'hFFFE && vector_priority_o == 6'h3F
        && vector_class_o == ivp_pkg::CLASS_RESET))
        else $error("reset cause did not take top vector");

    chk_sys_nmi: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (|req_i.sys_nmi_src && !(|req_i.reset_src)) |=> vector_addr_o == 16'hFFFC)
        else $error("system nmi vector wrong");

    chk_usr_nmi: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (|req_i.usr_nmi_src && !global_int_enable_i && !(|req_i.reset_src)
        && !(|req_i.sys_nmi_src)) |=> (vector_addr_o == 16'hFFFA && vector_priority_o == 6'h3D))
        else $error("user nmi vector wrong");

    chk_timer_index: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (req_i.timer0_grp == 3'h4) |=> index_o.timer0_vector_index == 8'h06)
        else $error("timer0 overflow index wrong");

    chk_gie_mask: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !global_int_enable_i |=> vector_class_o != ivp_pkg::CLASS_MASKABLE)
        else $error("maskable vector taken with gie clear");

    chk_wdog_slot: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (global_int_enable_i && req_i.watchdog_flag
        && gated_req[ivp_pkg::SLOT_NONE-1:ivp_pkg::SLOT_WDOG+1] == '0)
        |=> (vector_addr_o == 16'hFFEE && vector_priority_o == 6'h37))
        else $error("watchdog vector wrong");

    chk_sa_spi_mask: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (serial_a_spi_mode_i && req_i.serial_a == 4'h3) |=> index_o.serial_a_vector_index == 8'h00)
        else $error("serial A uart flag seen in spi mode");

    chk_port_order: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (global_int_enable_i && |req_i.port1 && |req_i.port2
        && gated_req[ivp_pkg::SLOT_NONE-1:ivp_pkg::SLOT_CONV] == '0)
        |=> vector_addr_o == 16'hFFE6)
        else $error("port1 did not outrank port2");

endmodule : ivp_vector_priority

`default_nettype wire

// [core/ivp_pkg.sv]
`default_nettype none

package ivp_pkg;

    // number of table entries: 11 source slots plus SLOT_NONE
    localparam int unsigned SRC_COUNT = 12;
    localparam int unsigned IDX_W = 8;

    // vector table window
    localparam logic [15:0] TABLE_TOP = 16'hFFFF;
    localparam logic [15:0] TABLE_BOTTOM = 16'hFF80;

    // source slots, lowest priority at slot 0
    localparam int unsigned SLOT_PORT2 = 0;
    localparam int unsigned SLOT_PORT1 = 1;
    localparam int unsigned SLOT_CONV = 2;
    localparam int unsigned SLOT_SER_B = 3;
    localparam int unsigned SLOT_SER_A = 4;
    localparam int unsigned SLOT_WDOG = 5;
    localparam int unsigned SLOT_T0_GRP = 6;
    localparam int unsigned SLOT_T0_CH0 = 7;
    localparam int unsigned SLOT_USR_NMI = 8;
    localparam int unsigned SLOT_SYS_NMI = 9;
    localparam int unsigned SLOT_RESET = 10;
    localparam int unsigned SLOT_NONE = 11;

    // word address of each slot's vector
    localparam logic [15:0] VEC_ADDR [SRC_COUNT] = '{
        16'hFFE4, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC, 16'hFFEE,
        16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE, 16'h0000};
    localparam logic [5:0] VEC_PRIO [SRC_COUNT] = '{
        6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37,
        6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h00};

    // field positions inside the serial groups
    localparam int unsigned SA_RX_BIT = 2;
    localparam int unsigned SA_TX_BIT = 3;
    localparam int unsigned SB_RX0_BIT = 4;
    localparam int unsigned SB_TX0_BIT = 5;
    localparam logic [3:0] SA_SPI_MASK = 4'hC;
    localparam logic [13:0] SB_SPI_MASK = 14'h0030;

    typedef enum logic [1:0]
    {
        CLASS_NONE = 2'b00,
        CLASS_RESET = 2'b01,
        CLASS_NMI = 2'b10,
        CLASS_MASKABLE = 2'b11
    } ivp_class_type;

    // request flags from every source
    typedef struct packed
    {
        logic [7:0] reset_src;   // por,bor,svs,pin,wdog/key,uncorr,sw por,fll
        logic [3:0] sys_nmi_src; // vacant, mbox in, mbox out, bit error
        logic [1:0] usr_nmi_src; // external nmi, oscillator fault
        logic compare_channel0_flag;
        logic [2:0] timer0_grp;  // ch1, ch2, timer0_overflow_flag
        logic watchdog_flag;
        logic [3:0] serial_a;    // tx complete, start, rx, tx
        logic [13:0] serial_b;   // al,nack,sta,stp,rx0,tx0..rx3,tx3,cnt,bit9
        logic [5:0] converter;   // done,in,lo,hi,tov,ov
        logic [7:0] port1;
        logic [7:0] port2;
    } ivp_req_type;

    // resolved index values of the shared vectors
    typedef struct packed
    {
        logic [7:0] timer0_vector_index;
        logic [7:0] serial_a_vector_index;
        logic [7:0] serial_b_vector_index;
        logic [7:0] converter_vector_index;
        logic [7:0] port1_vector_index;
        logic [7:0] port2_vector_index;
    } ivp_index_type;

endpackage : ivp_pkg

`default_nettype wire

// [tb/ivp_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ivp_cpu_model
(
    input wire logic sys_clk_i,                             // system clock
    input wire logic reset_i,                               // synchronous reset
    input wire logic vector_valid_i,                        // vector pending
    input wire logic [15:0] handler_ptr_i,                  // fetched pointer
    output logic [15:0] vector_word_o [ivp_pkg::SRC_COUNT], // table contents
    output logic [15:0] pc_o                                // program counter
);
    // distinct pointer per slot so a wrong slot cannot pass
    always_comb
    begin
        for (int s = 0; s < ivp_pkg::SRC_COUNT; s++)
        begin
            vector_word_o[s] = 16'hC000 + 16'(s * 16'h0111);
        end
    end

    // pc takes the fetched pointer whenever a vector is taken
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            pc_o <= 16'h0000;
        else if (vector_valid_i)
            pc_o <= handler_ptr_i;
    end
endmodule : ivp_cpu_model

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    ivp_pkg::ivp_req_type req = '0;
    logic gie = 1'b1;
    logic sa_spi = 1'b0;
    logic sb_i2c = 1'b1;
    logic [15:0] words [ivp_pkg::SRC_COUNT];
    logic valid;
    ivp_pkg::ivp_class_type cls;
    logic [15:0] addr;
    logic [5:0] prio;
    logic [15:0] ptr;
    logic [15:0] pc;
    ivp_pkg::ivp_index_type idx;
    int miscompares = 0;
    int checked = 0;
    // expected map per slot, written out independently of the package
    logic [15:0] exp_addr [11] = '{16'hFFE4, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC,
        16'hFFEE, 16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
    logic [5:0] exp_prio [11] = '{6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h3B,
        6'h3C, 6'h3D, 6'h3E, 6'h3F};

    always #20 sys_clk_i = ~sys_clk_i;

    ivp_vector_priority ivp_vector_priority_i
    (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
        .global_int_enable_i(gie), .serial_a_spi_mode_i(sa_spi),
        .serial_b_i2c_mode_i(sb_i2c), .vector_word_i(words), .vector_valid_o(valid),
        .vector_class_o(cls), .vector_addr_o(addr), .vector_priority_o(prio),
        .handler_ptr_o(ptr), .index_o(idx)
    );
    ivp_cpu_model ivp_cpu_model_i
    (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .vector_valid_i(valid),
        .handler_ptr_i(ptr), .vector_word_o(words), .pc_o(pc)
    );

    task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : cmp_val

    task automatic cmp_cls(input ivp_pkg::ivp_class_type exp);
        checked++;
        if (cls !== exp)
        begin
            $display("wrong value class expected %h seen %h", exp, cls);
            miscompares++;
        end
    endtask : cmp_cls

    // one flag of the group behind slot s; the serial flags chosen are ones both modes pass
    function automatic ivp_pkg::ivp_req_type one_src(input int s);
        ivp_pkg::ivp_req_type r;
        r = '0;
        case (s)
            0: r.port2 = 8'h80;
            1: r.port1 = 8'h01;
            2: r.converter = 6'h20;
            3: r.serial_b = 14'h0010;
            4: r.serial_a = 4'h4;
            5: r.watchdog_flag = 1'b1;
            6: r.timer0_grp = 3'h4;
            7: r.compare_channel0_flag = 1'b1;
            8: r.usr_nmi_src = 2'h2;
            9: r.sys_nmi_src = 4'h8;
            default: r.reset_src = 8'h80;
        endcase
        return r;
    endfunction : one_src

    // inputs change at the falling edge, result read at the next falling edge
    task automatic apply(input ivp_pkg::ivp_req_type r, input logic g);
        req = r;
        gie = g;
        @(negedge sys_clk_i);
    endtask : apply

    task automatic check_vec(input int s);
        ivp_pkg::ivp_class_type ec;
        ec = ivp_pkg::CLASS_MASKABLE;
        if (s >= 8)
            ec = (s >= 10) ? ivp_pkg::CLASS_RESET : ivp_pkg::CLASS_NMI;
        cmp_val("valid", 16'h0001, {15'h0, valid});
        cmp_cls(ec);
        cmp_val("addr", exp_addr[s], addr);
        cmp_val("prio", {10'h0, exp_prio[s]}, {10'h0, prio});
        cmp_val("ptr", 16'hC000 + 16'(s * 16'h0111), ptr);
    endtask : check_vec

    task automatic check_none();
        cmp_val("valid", 16'h0000, {15'h0, valid});
        cmp_cls(ivp_pkg::CLASS_NONE);
        cmp_val("addr", 16'h0000, addr);
        cmp_val("prio", 16'h0000, {10'h0, prio});
        cmp_val("ptr", 16'h0000, ptr);
    endtask : check_none

    task automatic t_each_slot();
        for (int s = 0; s < 11; s++)
        begin
            apply(one_src(s), 1'b1);
            check_vec(s);
        end
        // the cpu took the reset slot's pointer one edge after it stood
        apply('0, 1'b1);
        check_none();
        cmp_val("pc", 16'hCAAA, pc);
    endtask : t_each_slot

    // reset mid-run clears every output although causes stay pending
    task automatic t_reset();
        ivp_pkg::ivp_req_type r;
        r = one_src(10) | one_src(1);
        apply(r, 1'b1);
        check_vec(10);
        reset_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check_none();
        cmp_val("p1 idx", 16'h0000, {8'h0, idx.port1_vector_index});
        reset_i = 1'b0;
        apply(one_src(1), 1'b1);
        check_vec(1);
    endtask : t_reset

    // all pending, then the winner is withdrawn one slot at a time
    task automatic t_priority();
        ivp_pkg::ivp_req_type r;
        for (int s = 10; s >= 0; s--)
        begin
            r = '0;
            for (int k = 0; k <= s; k++)
                r = r | one_src(k);
            apply(r, 1'b1);
            check_vec(s);
        end
    endtask : t_priority

    // gie low hides maskables but not the user nmi slot
    task automatic t_gie();
        ivp_pkg::ivp_req_type r;
        r = '0;
        for (int k = 0; k < 8; k++)
            r = r | one_src(k);
        apply(r, 1'b0);
        check_none();
        apply(r | one_src(8), 1'b0);
        check_vec(8);
    endtask : t_gie

    // lowest pending bit picks the index, gie does not gate indexes
    task automatic t_index();
        ivp_pkg::ivp_req_type r;
        r = '0;
        r.timer0_grp = 3'h6;
        r.serial_a = 4'h3;
        r.serial_b = 14'h2000;
        r.converter = 6'h24;
        r.port1 = 8'h0C;
        r.port2 = 8'h80;
        apply(r, 1'b0);
        cmp_val("t0 idx", 16'h0004, {8'h0, idx.timer0_vector_index});
        cmp_val("sa idx", 16'h0002, {8'h0, idx.serial_a_vector_index});
        cmp_val("sb idx", 16'h001C, {8'h0, idx.serial_b_vector_index});
        cmp_val("cv idx", 16'h0006, {8'h0, idx.converter_vector_index});
        cmp_val("p1 idx", 16'h0006, {8'h0, idx.port1_vector_index});
        cmp_val("p2 idx", 16'h0010, {8'h0, idx.port2_vector_index});
    endtask : t_index

    // spi modes drop the uart-only and i2c-only flags
    task automatic t_modes();
        ivp_pkg::ivp_req_type r;
        r = '0;
        sa_spi = 1'b1;
        sb_i2c = 1'b0;
        r.serial_a = 4'h3;
        r.serial_b = 14'h200F;
        apply(r, 1'b1);
        check_none();
        r.serial_b = 14'h202F;
        apply(r, 1'b1);
        check_vec(3);
        cmp_val("sb idx", 16'h000C, {8'h0, idx.serial_b_vector_index});
        r.serial_a = 4'hB;
        apply(r, 1'b1);
        check_vec(4);
        cmp_val("sa idx", 16'h0008, {8'h0, idx.serial_a_vector_index});
    endtask : t_modes

    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // a reset cause is pending during reset, yet outputs must stay clear
    initial
    begin
        req = one_src(10);
        repeat (4) @(negedge sys_clk_i);
        check_none();
        reset_i = 1'b0;
        t_each_slot();
        t_priority();
        t_gie();
        t_index();
        t_reset();
        t_modes();
        close_out();
    end

    // the sequence needs well under 100 cycles
    initial
    begin
        #(40 * 2000);
        miscompares++;
        close_out();
    end
endmodule : tb_top

`default_nettype wire
